// >>> rtl/osiu_consts.svh
// Offsets, field positions, reset values and cycle counts for the timer and interrupt unit.
// Assumes inclusion by bare name from files under rtl/ and test/.
`ifndef OSIU_CONSTS_SVH
`define OSIU_CONSTS_SVH

// I/O block offsets, relative to the 16-byte block boundary.
`define OSIU_OFF_ISR_EOI 4'h0
`define OSIU_OFF_EDGE 4'h2
`define OSIU_OFF_MASK 4'h4
`define OSIU_OFF_LIR 4'h6
`define OSIU_OFF_VBASE 4'h8
`define OSIU_OFF_SLAVE 4'ha
`define OSIU_OFF_BAUD 4'hc
`define OSIU_OFF_TCW 4'he

// Timer control word read/write field.
`define OSIU_TCW_RW_HI 5
`define OSIU_TCW_RW_LO 4
`define OSIU_TCW_RW_BOTH 2'h3

// Reset values.
`define OSIU_MASK_RST 8'hff
`define OSIU_EDGE_RST 8'h00
`define OSIU_LIR_RST 8'hff
`define OSIU_VBASE_RST 8'h00
`define OSIU_SLAVE_RST 8'h00
`define OSIU_TCW_RST 8'h00

// Bus cycle: last phase index after T1 (T2=1, T3=2, T4=3).
`define OSIU_LAST_PH 2'h3

// Host APB register byte addresses.
`define OSIU_APB_CMD 12'h000
`define OSIU_APB_STAT 12'h004
`define OSIU_APB_RES 12'h008

// Host command field positions.
`define OSIU_CMD_OFF_LO 0
`define OSIU_CMD_DATA_LO 8
`define OSIU_CMD_OP_LO 16

`endif

// >>> rtl/osiu_pkg.sv
// Types of the timer and interrupt unit; only the status codes are used by both ends, the rest by the host end.
// Assumes the constants header is included by the files that need numbers.
package osiu_pkg;

  // Bus cycle codes on the CPU status lines.
  typedef enum logic [2:0] {
    st_inta = 3'h0,
    st_io_rd = 3'h1,
    st_io_wr = 3'h2,
    st_passive = 3'h7
  } osiu_status_t;

  // Host command operations.
  typedef enum logic [1:0] {
    op_read = 2'h0,
    op_write = 2'h1,
    op_inta = 2'h2
  } osiu_op_t;

  // Host bus sequencer states.
  typedef enum logic [1:0] {
    h_idle,
    h_t1,
    h_data,
    h_gap
  } osiu_hstate_t;

endpackage

// >>> rtl/osiu_link_if.sv
// Local multiplexed bus between the host CPU end and the timer and interrupt unit.
// Assumes both ends run on ref_clk; the shared address/data wire is resolved here.
`timescale 1ns/1ns
interface osiu_link_if (
  input wire logic ref_clk
);
  osiu_pkg::osiu_status_t cpu_status_code;
  logic io_block_select_n;
  logic [15:0] ad_host;
  logic ad_host_oe_n;
  logic [15:0] ad_dev;
  logic [1:0] ad_dev_oe_n;
  logic [15:0] ad;
  logic intr;
  logic ack_n;
  logic local_ack_indicator;

  // Device lanes win where enabled, else host, else the pull-up level.
  assign ad[7:0] = !ad_dev_oe_n[0] ? ad_dev[7:0] : !ad_host_oe_n ? ad_host[7:0] : 8'hff;
  assign ad[15:8] = !ad_dev_oe_n[1] ? ad_dev[15:8] : !ad_host_oe_n ? ad_host[15:8] : 8'hff;

  modport dev_mp (
    input ref_clk, cpu_status_code, io_block_select_n, ad,
    output ad_dev, ad_dev_oe_n, intr, ack_n, local_ack_indicator
  );
  modport host_mp (
    input ref_clk, ad, intr, ack_n, local_ack_indicator,
    output cpu_status_code, io_block_select_n, ad_host, ad_host_oe_n
  );
endinterface

// >>> rtl/osiu_baud_gen.sv
// Square-wave baud generator counting on every clock once loaded.
// Assumes load is a one-cycle pulse with count stable on that cycle.
`timescale 1ns/1ns
module osiu_baud_gen #(
  parameter int CW = 16
) (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic rst,
  // Count register.
  input wire logic load,
  input wire logic [CW-1:0] count,
  // Waveform and readback.
  output logic baud_out,
  output logic [CW-1:0] cur_count
);
  logic run_ff;
  logic out_ff;
  logic [CW:0] cnt_ff;
  logic [CW:0] full_n;
  logic [CW:0] hi_len;
  logic [CW:0] lo_len;
  logic last;

  // A count of zero stands for the full range.
  assign full_n = (count == '0) ? {1'b1, {CW{1'b0}}} : {1'b0, count};
  assign hi_len = (full_n + 1'b1) >> 1;
  assign lo_len = full_n >> 1;
  assign last = (cnt_ff == {{CW{1'b0}}, 1'b1});

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      run_ff <= 1'b0;
      out_ff <= 1'b1;
      cnt_ff <= '0;
    end else if (load) begin
      run_ff <= 1'b1;
      out_ff <= 1'b1;
      cnt_ff <= hi_len;
    end else if (run_ff) begin
      if (last && out_ff && lo_len != '0) begin
        out_ff <= 1'b0;
        cnt_ff <= lo_len;
      end else if (last) begin
        out_ff <= 1'b1;
        cnt_ff <= hi_len;
      end else begin
        cnt_ff <= cnt_ff - 1'b1;
      end
    end
  end

  assign baud_out = out_ff;
  assign cur_count = cnt_ff[CW-1:0];
endmodule

// >>> rtl/osiu_dev_end.sv
// Timer and interrupt unit: device end on the host's local multiplexed bus.
// Assumes the host runs T1..T4 cycles on ref_clk with a passive cycle between them.
// Summary of operation
// - Timer bytes on low lane, even addresses, LSB first.
// - MSB latched at read start until read.
// - Timers count freely, no gate input.
// - Baud output high until count loaded.
// - First edge after load starts the counter.
// - High ceil(N/2), low floor(N/2) clocks.
// - End of low phase: output high, reload.
// - Baud count 0CH, control 0EH, select needed.
// - Software leaves timers 0 and 1 alone.
// - Host writes 0B6H then count, LSB first.
// - Eight prioritised vectored request inputs.
// - Each input set edge or level.
// - Tick timer wired to a request input; no tick timer here, all eight come from request_inputs.
// - Cascaded slave controllers extend the sources.
// - Local ack indicator driven during acknowledges.
// - Rising edge or high level registers requests.
// - Raise interrupt when pending beats in-service.
// - CPU answers with two acknowledge cycles.
// - First acknowledge: set in-service, clear edge, ack.
// - Second acknowledge: cascade address, vector, ack.
// - In-service holds until end-of-interrupt command.
// - Block sits on a 16-byte boundary.
//
// The APB slave port was left to the implementer.
`timescale 1ns/1ns
`include "osiu_consts.svh"
module osiu_dev_end #(
  parameter int NREQ = 8
) (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic rst,
  // Host bus.
  osiu_link_if.dev_mp link,
  // Request pins.
  input wire logic [NREQ-1:0] request_inputs,
  // Baud clock.
  output logic baud_out
);
  // Request synchronisers and edge history.
  logic [NREQ-1:0] req_s1_ff;
  logic [NREQ-1:0] req_s2_ff;
  logic [NREQ-1:0] req_s3_ff;
  // Configuration.
  logic [7:0] edge_sel_ff;
  logic [7:0] mask_ff;
  logic [7:0] lir_cfg_ff;
  logic [7:0] vbase_ff;
  logic [7:0] slave_ff;
  logic [7:0] tcw_ff;
  // Interrupt state.
  logic [7:0] edge_lat_ff;
  logic [7:0] in_service_flag_ff;
  logic inta_second_ff;
  logic [2:0] ack_idx_ff;
  logic intr_ff;
  // Bus cycle tracking.
  osiu_pkg::osiu_status_t st_prev_ff;
  osiu_pkg::osiu_status_t cyc_ff;
  logic active_ff;
  logic [1:0] ph_ff;
  logic [3:0] addr_ff;
  logic sel_ff;
  // Bus outputs.
  logic [15:0] dout_ff;
  logic [1:0] oe_n_ff;
  logic ack_n_ff;
  logic lir_out_ff;
  // Baud count register.
  logic [7:0] cnt_lo_ff;
  logic [7:0] cnt_hi_ff;
  logic wr_hi_ff;
  logic load_ff;
  logic [7:0] msb_latch_ff;
  logic msb_pend_ff;
  logic [15:0] cur_count;

  // Priority search: lowest index wins.
  function automatic logic [3:0] first_set(input logic [7:0] v);
    logic [3:0] r;
    r = 4'h0;
    for (int i = 7; i >= 0; i--) begin
      if (v[i]) begin
        r = {1'b1, 3'(i)};
      end
    end
    return r;
  endfunction

  // Decode of the current and starting cycles.
  wire t1 = (link.cpu_status_code != osiu_pkg::st_passive) &&
            (st_prev_ff == osiu_pkg::st_passive);
  wire t1_sel = !link.io_block_select_n;
  wire t1_even = (link.ad[0] == 1'b0);
  wire [3:0] t1_addr = link.ad[3:0];
  wire t1_rd = t1 && t1_sel && t1_even && (link.cpu_status_code == osiu_pkg::st_io_rd);
  wire t1_wr = t1 && t1_sel && t1_even && (link.cpu_status_code == osiu_pkg::st_io_wr);
  wire t1_inta = t1 && (link.cpu_status_code == osiu_pkg::st_inta);
  wire cyc_end = active_ff && (ph_ff == `OSIU_LAST_PH);
  wire wr_now = cyc_end && sel_ff && !addr_ff[0] && (cyc_ff == osiu_pkg::st_io_wr);
  wire [7:0] wdata = link.ad[7:0];

  // Pending requests and priority.
  wire [7:0] rise = req_s2_ff & ~req_s3_ff & edge_sel_ff;
  wire [7:0] pend = ((edge_lat_ff & edge_sel_ff) | (req_s2_ff & ~edge_sel_ff)) & ~mask_ff;
  wire [3:0] pend_top = first_set(pend);
  wire [3:0] isr_top = first_set(in_service_flag_ff);
  wire want_int = pend_top[3] && (!isr_top[3] || pend_top[2:0] < isr_top[2:0]);
  wire [2:0] pick_idx = pend_top[3] ? pend_top[2:0] : 3'h7;
  wire inta1 = t1_inta && !inta_second_ff;
  wire inta2 = t1_inta && inta_second_ff;
  wire [7:0] ack_set = (inta1 && pend_top[3]) ? (8'h01 << pick_idx) : 8'h00;
  wire end_of_interrupt_cmd = wr_now && (addr_ff == `OSIU_OFF_ISR_EOI);
  wire [7:0] eoi_clr = (end_of_interrupt_cmd && isr_top[3]) ? (8'h01 << isr_top[2:0]) : 8'h00;
  wire supply_vec = !slave_ff[ack_idx_ff];
  wire [7:0] vector = {vbase_ff[7:3], ack_idx_ff};

  // Register writes.
  wire tcw_both = (tcw_ff[`OSIU_TCW_RW_HI:`OSIU_TCW_RW_LO] == `OSIU_TCW_RW_BOTH);
  wire wr_baud = wr_now && (addr_ff == `OSIU_OFF_BAUD) && tcw_both;
  wire wr_tcw = wr_now && (addr_ff == `OSIU_OFF_TCW);

  // Read data chosen at T1.
  wire rd_baud = t1_rd && (t1_addr == `OSIU_OFF_BAUD);
  wire [7:0] baud_byte = msb_pend_ff ? msb_latch_ff : cur_count[7:0];
  wire [7:0] rd_mux =
    (t1_addr == `OSIU_OFF_ISR_EOI) ? in_service_flag_ff :
    (t1_addr == `OSIU_OFF_EDGE) ? edge_sel_ff :
    (t1_addr == `OSIU_OFF_MASK) ? mask_ff :
    (t1_addr == `OSIU_OFF_LIR) ? lir_cfg_ff :
    (t1_addr == `OSIU_OFF_VBASE) ? vbase_ff :
    (t1_addr == `OSIU_OFF_SLAVE) ? slave_ff :
    (t1_addr == `OSIU_OFF_BAUD) ? baud_byte : 8'h00;

  // Request pin synchronisers.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      req_s1_ff <= '0;
      req_s2_ff <= '0;
      req_s3_ff <= '0;
    end else begin
      req_s1_ff <= request_inputs;
      req_s2_ff <= req_s1_ff;
      req_s3_ff <= req_s2_ff;
    end
  end

  // Configuration registers.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      edge_sel_ff <= `OSIU_EDGE_RST;
      mask_ff <= `OSIU_MASK_RST;
      lir_cfg_ff <= `OSIU_LIR_RST;
      vbase_ff <= `OSIU_VBASE_RST;
      slave_ff <= `OSIU_SLAVE_RST;
      tcw_ff <= `OSIU_TCW_RST;
    end else if (wr_now) begin
      if (addr_ff == `OSIU_OFF_EDGE) edge_sel_ff <= wdata;
      if (addr_ff == `OSIU_OFF_MASK) mask_ff <= wdata;
      if (addr_ff == `OSIU_OFF_LIR) lir_cfg_ff <= wdata;
      if (addr_ff == `OSIU_OFF_VBASE) vbase_ff <= wdata;
      if (addr_ff == `OSIU_OFF_SLAVE) slave_ff <= wdata;
      if (addr_ff == `OSIU_OFF_TCW) tcw_ff <= wdata;
    end
  end

  // Interrupt state: sets win over clears.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      edge_lat_ff <= '0;
      in_service_flag_ff <= '0;
      inta_second_ff <= 1'b0;
      ack_idx_ff <= 3'h0;
      intr_ff <= 1'b0;
    end else begin
      edge_lat_ff <= (edge_lat_ff & ~ack_set) | rise;
      in_service_flag_ff <= (in_service_flag_ff & ~eoi_clr) | ack_set;
      if (t1_inta) inta_second_ff <= !inta_second_ff;
      if (inta1) ack_idx_ff <= pick_idx;
      intr_ff <= want_int && !inta_second_ff && !inta1;
    end
  end

  // Bus cycle tracking.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st_prev_ff <= osiu_pkg::st_passive;
      cyc_ff <= osiu_pkg::st_passive;
      active_ff <= 1'b0;
      ph_ff <= 2'h0;
      addr_ff <= 4'h0;
      sel_ff <= 1'b0;
    end else begin
      st_prev_ff <= link.cpu_status_code;
      if (t1) begin
        active_ff <= 1'b1;
        ph_ff <= 2'h1;
        cyc_ff <= link.cpu_status_code;
        addr_ff <= t1_addr;
        sel_ff <= t1_sel;
      end else if (cyc_end) begin
        active_ff <= 1'b0;
      end else if (active_ff) begin
        ph_ff <= ph_ff + 2'h1;
      end
    end
  end

  // Bus answers for T2..T4.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      dout_ff <= 16'h0000;
      oe_n_ff <= 2'h3;
      ack_n_ff <= 1'b1;
      lir_out_ff <= 1'b1;
    end else if (t1_rd) begin
      dout_ff <= {8'h00, rd_mux};
      oe_n_ff <= 2'h2;
      ack_n_ff <= 1'b0;
    end else if (t1_wr) begin
      ack_n_ff <= 1'b0;
    end else if (inta1) begin
      oe_n_ff <= 2'h3;
      ack_n_ff <= 1'b0;
      lir_out_ff <= lir_cfg_ff[pick_idx];
    end else if (inta2) begin
      dout_ff <= {5'h00, ack_idx_ff, vector};
      oe_n_ff <= {1'b0, !supply_vec};
      ack_n_ff <= !supply_vec;
      lir_out_ff <= lir_cfg_ff[ack_idx_ff];
    end else if (cyc_end) begin
      oe_n_ff <= 2'h3;
      ack_n_ff <= 1'b1;
      lir_out_ff <= 1'b1;
    end
  end

  // Baud count register and MSB read latch.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cnt_lo_ff <= 8'h00;
      cnt_hi_ff <= 8'h00;
      wr_hi_ff <= 1'b0;
      load_ff <= 1'b0;
      msb_latch_ff <= 8'h00;
      msb_pend_ff <= 1'b0;
    end else begin
      load_ff <= wr_baud && wr_hi_ff;
      if (wr_tcw) begin
        wr_hi_ff <= 1'b0;
        msb_pend_ff <= 1'b0;
      end else if (wr_baud && !wr_hi_ff) begin
        cnt_lo_ff <= wdata;
        wr_hi_ff <= 1'b1;
      end else if (wr_baud) begin
        cnt_hi_ff <= wdata;
        wr_hi_ff <= 1'b0;
      end
      if (rd_baud && !msb_pend_ff) begin
        msb_latch_ff <= cur_count[15:8];
        msb_pend_ff <= 1'b1;
      end else if (rd_baud) begin
        msb_pend_ff <= 1'b0;
      end
    end
  end

  osiu_baud_gen #(
    .CW(16)
  ) u_baud (
    .ref_clk(ref_clk),
    .rst(rst),
    .load(load_ff),
    .count({cnt_hi_ff, cnt_lo_ff}),
    .baud_out(baud_out),
    .cur_count(cur_count)
  );

  assign link.ad_dev = dout_ff;
  assign link.ad_dev_oe_n = oe_n_ff;
  assign link.intr = intr_ff;
  assign link.ack_n = ack_n_ff;
  assign link.local_ack_indicator = lir_out_ff;
endmodule

// >>> rtl/osiu_host_end.sv
// Host CPU end: runs I/O and acknowledge cycles ordered over APB.
// Assumes an APB master on ref_clk and the device end on the same link.
`timescale 1ns/1ns
`include "osiu_consts.svh"
module osiu_host_end (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic rst,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Device bus.
  osiu_link_if.host_mp link
);
  osiu_pkg::osiu_hstate_t st_ff;
  osiu_pkg::osiu_op_t op_ff;
  logic [3:0] off_ff;
  logic [7:0] wdat_ff;
  logic second_ff;
  logic [1:0] ph_ff;
  logic busy_ff;
  osiu_pkg::osiu_status_t code_ff;
  logic sel_n_ff;
  logic [15:0] ad_ff;
  logic oe_n_ff;
  logic [7:0] rdat_ff;
  logic [7:0] vec_ff;
  logic [2:0] casc_ff;
  logic vec_ok_ff;
  logic lir_ff;
  logic [31:0] prdata_ff;
  logic pready_ff;

  // APB decode; one wait state on every access.
  wire acc = psel && penable && !pready_ff;
  wire done = psel && penable && pready_ff;
  wire cmd_wr = done && pwrite && (paddr == `OSIU_APB_CMD) && !busy_ff;
  wire [1:0] cmd_op = pwdata[`OSIU_CMD_OP_LO+1:`OSIU_CMD_OP_LO];
  wire [31:0] rd_mux =
    (paddr == `OSIU_APB_STAT) ? {29'h0, link.local_ack_indicator, link.intr, busy_ff} :
    (paddr == `OSIU_APB_RES) ? {6'h0, lir_ff, vec_ok_ff, 5'h0, casc_ff, vec_ff, rdat_ff} :
    32'h0;
  wire is_inta = (op_ff == osiu_pkg::op_inta);
  wire [1:0] nxt_ph = ph_ff + 2'h1;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      prdata_ff <= 32'h0;
      pready_ff <= 1'b0;
    end else begin
      pready_ff <= acc;
      if (acc && !pwrite) prdata_ff <= rd_mux;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st_ff <= osiu_pkg::h_idle;
      op_ff <= osiu_pkg::op_read;
      off_ff <= 4'h0;
      wdat_ff <= 8'h00;
      second_ff <= 1'b0;
      ph_ff <= 2'h0;
      busy_ff <= 1'b0;
      code_ff <= osiu_pkg::st_passive;
      sel_n_ff <= 1'b1;
      ad_ff <= 16'h0000;
      oe_n_ff <= 1'b1;
      rdat_ff <= 8'h00;
      vec_ff <= 8'h00;
      casc_ff <= 3'h0;
      vec_ok_ff <= 1'b0;
      lir_ff <= 1'b1;
    end else begin
      case (st_ff)
        osiu_pkg::h_idle: begin
          if (cmd_wr && cmd_op != 2'h3) begin
            op_ff <= osiu_pkg::osiu_op_t'(cmd_op);
            off_ff <= pwdata[`OSIU_CMD_OFF_LO+3:`OSIU_CMD_OFF_LO];
            wdat_ff <= pwdata[`OSIU_CMD_DATA_LO+7:`OSIU_CMD_DATA_LO];
            second_ff <= 1'b0;
            busy_ff <= 1'b1;
            st_ff <= osiu_pkg::h_t1;
            code_ff <= (cmd_op == 2'h0) ? osiu_pkg::st_io_rd :
                       (cmd_op == 2'h1) ? osiu_pkg::st_io_wr : osiu_pkg::st_inta;
            sel_n_ff <= (cmd_op == 2'h2);
            ad_ff <= {12'h000, pwdata[`OSIU_CMD_OFF_LO+3:`OSIU_CMD_OFF_LO]};
            oe_n_ff <= 1'b0;
          end
        end
        osiu_pkg::h_t1: begin
          st_ff <= osiu_pkg::h_data;
          ph_ff <= 2'h1;
          ad_ff <= {8'h00, wdat_ff};
          oe_n_ff <= (op_ff != osiu_pkg::op_write);
        end
        osiu_pkg::h_data: begin
          ph_ff <= nxt_ph;
          if (ph_ff == `OSIU_LAST_PH) begin
            st_ff <= osiu_pkg::h_gap;
            code_ff <= osiu_pkg::st_passive;
            sel_n_ff <= 1'b1;
            oe_n_ff <= 1'b1;
            if (op_ff == osiu_pkg::op_read) rdat_ff <= link.ad[7:0];
            if (is_inta) lir_ff <= link.local_ack_indicator;
            if (is_inta && second_ff) begin
              casc_ff <= link.ad[10:8];
              vec_ok_ff <= !link.ack_n;
              vec_ff <= link.ad[7:0];
            end
          end
        end
        osiu_pkg::h_gap: begin
          if (is_inta && !second_ff) begin
            second_ff <= 1'b1;
            st_ff <= osiu_pkg::h_t1;
            code_ff <= osiu_pkg::st_inta;
            ad_ff <= 16'h0000;
          end else begin
            st_ff <= osiu_pkg::h_idle;
            busy_ff <= 1'b0;
          end
        end
        default: begin
          st_ff <= osiu_pkg::h_idle;
        end
      endcase
    end
  end

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = 1'b0;
  assign link.cpu_status_code = code_ff;
  assign link.io_block_select_n = sel_n_ff;
  assign link.ad_host = ad_ff;
  assign link.ad_host_oe_n = oe_n_ff;
endmodule

// >>> test/osiu_link_props.sv
// Assertions on the link between the host end and the device end, and on the baud output.
// Assumes instantiation beside the link interface, everything on ref_clk.
`timescale 1ns/1ns
module osiu_link_props (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic rst,
  // Link signals.
  input wire osiu_pkg::osiu_status_t cpu_status_code,
  input wire logic io_block_select_n,
  input wire logic [15:0] ad,
  input wire logic [1:0] ad_dev_oe_n,
  input wire logic ack_n,
  input wire logic local_ack_indicator,
  // Baud clock.
  input wire logic baud_out
);
  osiu_pkg::osiu_status_t prev_st_ff;
  logic inta_num_ff, last_ff;
  logic [3:0] addr_ff;
  logic [1:0] falls_ff;
  logic [16:0] run_ff, hi_ff;
  wire logic is_inta = cpu_status_code == osiu_pkg::st_inta;
  wire logic cyc_start = cpu_status_code != osiu_pkg::st_passive &&
    prev_st_ff == osiu_pkg::st_passive;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  // Latch the cycle address and tell the first acknowledge cycle from the second.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      prev_st_ff <= osiu_pkg::st_passive;
      inta_num_ff <= 1'b0;
      addr_ff <= 4'h0;
    end else begin
      prev_st_ff <= cpu_status_code;
      if (cyc_start) begin
        addr_ff <= ad[3:0];
        inta_num_ff <= is_inta ? !inta_num_ff : inta_num_ff;
      end
    end
  end

  // Measure the length of each baud phase.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      last_ff <= 1'b1;
      run_ff <= 17'h0;
      hi_ff <= 17'h0;
      falls_ff <= 2'h0;
    end else begin
      last_ff <= baud_out;
      run_ff <= (baud_out != last_ff) ? 17'h1 : run_ff + 17'h1;
      if (last_ff && !baud_out) begin
        hi_ff <= run_ff;
        falls_ff <= (falls_ff == 2'h2) ? 2'h2 : falls_ff + 2'h1;
      end
    end
  end

  property p_ack_len;
    $fell(ack_n) |-> !ack_n [*3] ##1 ack_n;
  endproperty
  a_ack_len: assert property (p_ack_len) else $error("ack low time wrong");
  property p_ack_sel;
    $fell(ack_n) && !is_inta |-> !io_block_select_n && !addr_ff[0];
  endproperty
  a_ack_sel: assert property (p_ack_sel) else $error("ack without select");
  property p_idle;
    cpu_status_code == osiu_pkg::st_passive && $past(cpu_status_code) == osiu_pkg::st_passive
      |-> ack_n && ad_dev_oe_n == 2'h3;
  endproperty
  a_idle: assert property (p_idle) else $error("device active while idle");
  property p_lir;
    $fell(local_ack_indicator) |-> is_inta && !ack_n;
  endproperty
  a_lir: assert property (p_lir) else $error("local ack outside acknowledge");
  property p_inta1;
    is_inta && inta_num_ff |-> ad_dev_oe_n == 2'h3;
  endproperty
  a_inta1: assert property (p_inta1) else $error("bus driven in first ack");
  property p_inta2;
    is_inta && !inta_num_ff && !ack_n |-> ad[10:8] == ad[2:0] && ad[15:11] == 5'h0 &&
      ad_dev_oe_n == 2'h0;
  endproperty
  a_inta2: assert property (p_inta2) else $error("cascade or vector wrong");
  property p_baud_rst;
    $fell(rst) |-> baud_out [*8];
  endproperty
  a_baud_rst: assert property (p_baud_rst) else $error("baud low after reset");
  property p_baud_duty;
    baud_out && !last_ff && falls_ff == 2'h2 |-> hi_ff == run_ff || hi_ff == run_ff + 17'h1;
  endproperty
  a_baud_duty: assert property (p_baud_duty) else $error("baud duty wrong");
endmodule

// >>> test/os_timer_interrupt_unit_test.sv
// Bench: host end and device end joined by the link, driven over APB and request pins.
// Assumes the design files, the constants header and the checker are compiled first.
`timescale 1ns/1ns
`include "osiu_consts.svh"
module os_timer_interrupt_unit_test;
  logic ref_clk, rst, psel, penable, pwrite, pready, pslverr, baud_out, lir_seen;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, res;
  logic [7:0] request_inputs, lsb, rq;
  logic [15:0] nv [3] = '{16'h0007, 16'h0034, 16'h0103};
  integer error_cnt, comparisons, seed, i, k, w, idx, n_lo, n_hi;

  osiu_link_if u_osiu_link_if (.ref_clk(ref_clk));
  osiu_host_end u_osiu_host_end (.ref_clk(ref_clk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .link(u_osiu_link_if));
  osiu_dev_end #(.NREQ(8)) u_osiu_dev_end (.ref_clk(ref_clk), .rst(rst),
    .link(u_osiu_link_if), .request_inputs(request_inputs), .baud_out(baud_out));
  osiu_link_props u_osiu_link_props (.ref_clk(ref_clk), .rst(rst),
    .cpu_status_code(u_osiu_link_if.cpu_status_code),
    .io_block_select_n(u_osiu_link_if.io_block_select_n), .ad(u_osiu_link_if.ad),
    .ad_dev_oe_n(u_osiu_link_if.ad_dev_oe_n), .ack_n(u_osiu_link_if.ack_n),
    .local_ack_indicator(u_osiu_link_if.local_ack_indicator), .baud_out(baud_out));

  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  // Record the local acknowledge level while an acknowledge is answered.
  always @(negedge ref_clk) begin
    if (u_osiu_link_if.cpu_status_code == osiu_pkg::st_inta && !u_osiu_link_if.ack_n) begin
      lir_seen = u_osiu_link_if.local_ack_indicator;
    end
  end

  task automatic end_sim();
    if (error_cnt == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic fail_out();
    error_cnt = error_cnt + 1;
    $display("MISMATCH wait expected done seen timeout");
    end_sim();
  endtask

  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    comparisons = comparisons + 1;
    if (got !== exp) begin
      error_cnt = error_cnt + 1;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask

  // Model of the priority order: input 0 wins.
  function automatic integer low_bit(input logic [7:0] r);
    integer j;
    low_bit = 8;
    for (j = 7; j >= 0; j--) if (r[j] === 1'b1) low_bit = j;
  endfunction

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
    output logic [31:0] q);
    integer n;
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk);
      n = n + 1;
    end while (pready !== 1'b1 && n < 50);
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) fail_out();
  endtask

  task automatic link_op(input logic [1:0] op, input logic [3:0] off, input logic [7:0] d);
    integer n;
    logic [31:0] q;
    apb(1'b1, `OSIU_APB_CMD, {14'h0, op, d, 4'h0, off}, q);
    q = 32'h1;
    for (n = 0; n < 100 && q[0] !== 1'b0; n++) apb(1'b0, `OSIU_APB_STAT, 32'h0, q);
    if (q[0] !== 1'b0) fail_out();
    apb(1'b0, `OSIU_APB_RES, 32'h0, res);
  endtask

  task automatic phase(input logic lvl, output integer n);
    integer t;
    t = 0;
    n = 0;
    @(negedge ref_clk);
    while (baud_out === lvl && t < 3000) begin
      @(negedge ref_clk);
      t = t + 1;
    end
    while (baud_out !== lvl && t < 3000) begin
      @(negedge ref_clk);
      t = t + 1;
    end
    while (baud_out === lvl && n < 3000) begin
      @(negedge ref_clk);
      n = n + 1;
    end
    if (t >= 3000 || n >= 3000) fail_out();
  endtask

  initial begin
    seed = 32'h64e2;
    error_cnt = 0;
    comparisons = 0;
    rst = 1'b1;
    {psel, penable, pwrite} = 3'h0;
    paddr = 12'h0;
    pwdata = 32'h0;
    request_inputs = 8'h00;
    lir_seen = 1'b1;
    repeat (16) @(posedge ref_clk);
    rst <= 1'b0;
    for (k = 0; k < 3; k++) begin
      if (k > 0) begin
        rst <= 1'b1;
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
      end
      link_op(osiu_pkg::op_write, `OSIU_OFF_BAUD, 8'h05);
      link_op(osiu_pkg::op_write, `OSIU_OFF_BAUD, 8'h00);
      @(negedge ref_clk);
      check("baud_idle", 32'h1, {31'h0, baud_out});
      link_op(osiu_pkg::op_write, `OSIU_OFF_TCW, 8'hb6);
      link_op(osiu_pkg::op_write, `OSIU_OFF_BAUD, nv[k][7:0]);
      link_op(osiu_pkg::op_write, `OSIU_OFF_BAUD, nv[k][15:8]);
      phase(1'b0, n_lo);
      phase(1'b1, n_hi);
      check("baud_low", 32'(nv[k] / 2), n_lo);
      check("baud_high", 32'((nv[k] + 1) / 2), n_hi);
      link_op(osiu_pkg::op_read, `OSIU_OFF_BAUD, 8'h00);
      lsb = res[7:0];
      link_op(osiu_pkg::op_read, `OSIU_OFF_BAUD, 8'h00);
      check("baud_rdback", 32'h1, {31'h0, {res[7:0], lsb} <= nv[k]});
    end
    link_op(osiu_pkg::op_read, 4'hd, 8'h00);
    check("odd_read", 32'hff, {24'h0, res[7:0]});
    request_inputs <= 8'hff;
    repeat (10) @(posedge ref_clk);
    apb(1'b0, `OSIU_APB_STAT, 32'h0, res);
    check("masked_intr", 32'h0, {31'h0, res[1]});
    request_inputs <= 8'h00;
    link_op(osiu_pkg::op_write, `OSIU_OFF_EDGE, 8'h01);
    link_op(osiu_pkg::op_write, `OSIU_OFF_LIR, 8'hfe);
    link_op(osiu_pkg::op_write, `OSIU_OFF_VBASE, 8'h48);
    link_op(osiu_pkg::op_write, `OSIU_OFF_MASK, 8'h00);
    for (i = 0; i < 8; i++) begin
      rq = $random(seed);
      rq = (i == 0) ? 8'h01 : (rq & (8'hff << i)) | (8'h01 << i);
      idx = low_bit(rq);
      request_inputs <= rq;
      if (i == 0) begin
        repeat (3) @(posedge ref_clk);
        request_inputs <= 8'h00;
      end
      res = 32'h0;
      for (w = 0; w < 20 && res[1] !== 1'b1; w++) apb(1'b0, `OSIU_APB_STAT, 32'h0, res);
      check("intr_up", 32'h1, {31'h0, res[1]});
      if (res[1] !== 1'b1) end_sim();
      lir_seen = 1'bx;
      link_op(osiu_pkg::op_inta, 4'h0, 8'h00);
      check("vector", 32'h48 | idx, {24'h0, res[15:8]});
      check("cascade", idx, {29'h0, res[18:16]});
      check("vec_ok", 32'h1, {31'h0, res[24]});
      check("local_ack", 32'(idx != 0), {31'h0, lir_seen});
      check("lir_res", 32'(idx != 0), {31'h0, res[25]});
      link_op(osiu_pkg::op_read, `OSIU_OFF_ISR_EOI, 8'h00);
      check("in_service", 32'h1 << idx, {24'h0, res[7:0]});
      apb(1'b0, `OSIU_APB_STAT, 32'h0, res);
      check("intr_nested", 32'h0, {31'h0, res[1]});
      request_inputs <= 8'h00;
      link_op(osiu_pkg::op_write, `OSIU_OFF_ISR_EOI, 8'h00);
      link_op(osiu_pkg::op_read, `OSIU_OFF_ISR_EOI, 8'h00);
      check("eoi", 32'h0, {24'h0, res[7:0]});
      apb(1'b0, `OSIU_APB_STAT, 32'h0, res);
      check("intr_idle", 32'h0, {31'h0, res[1]});
    end
    end_sim();
  end
endmodule
